// ### core/nonrestoring_divider.sv
// Purpose: sequential signed non-restoring divider, 32 / 16 bits
// Assumes: operands held stable while busy, start is a one-cycle pulse
// Notes:   one quotient bit per clock, then one corrective cycle
`timescale 1ns/1ps
`default_nettype none
`include "divider_regs.svh"

// Behaviour
// - deliver quotient and remainder per division
// - flag overflow when quotient does not fit
// - underflow means step flipped remainder sign
// - working register starts holding the dividend
// - first divisor scaled to quotient MSB weight
// - halve scaled divisor before each later step
// - subtract on equal signs, add otherwise
// - no immediate restore, later steps recover
// - subtraction: bit one unless underflow
// - addition: bit zero unless underflow
// - final corrective step fixes leftover underflow
module nonrestoring_divider
    import divider_pkg::*;
(
    input  wire logic                 clock_in,
    input  wire logic                 resetn_in,
    input  wire logic                 start_in,
    input  wire logic [`DIVD_W-1:0]   dividend_in,
    input  wire logic [`DSR_W-1:0]    divisor_in,
    output logic                      busy_out,
    output logic                      done_out,
    output logic      [`DSR_W-1:0]    quotient_out,
    output logic      [`DSR_W-1:0]    remainder_out,
    output logic                      overflow_out
);

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta;
    logic rst_n;

    // two-stage release of the asynchronous reset
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ****************************************
    // datapath state
    // ****************************************
    div_state_t          state;
    div_state_t          next_state;
    logic [`WORK_W-1:0]  rem;
    logic [`WORK_W-1:0]  next_rem;
    logic [`WORK_W-1:0]  dsr;
    logic [`WORK_W-1:0]  next_dsr;
    logic [`DSR_W-1:0]   q;
    logic [`DSR_W-1:0]   next_q;
    logic [`CNT_W-1:0]   cnt;
    logic [`CNT_W-1:0]   next_cnt;
    logic                dvd_sign;
    logic                next_dvd_sign;
    logic                done;
    logic                next_done;
    logic [`DSR_W-1:0]   next_quotient;
    logic [`DSR_W-1:0]   next_remainder;
    logic                next_overflow;
    logic                qcarry;          // fix-step carry, marks a wrapped quotient
    logic                next_qcarry;

    logic [`WORK_W-1:0]  sum;
    logic                op_sub;
    logic                underflow;
    logic                qbit;
    logic                need_fix;
    logic [`DSR_W-1:0]   q_full;
    logic [`WORK_W-1:0]  abs_rem;
    logic [`WORK_W-1:0]  abs_dsr;
    logic [`WORK_W-1:0]  dvd_ext;
    logic [`WORK_W-1:0]  dsr_scaled;

    // operand forms loaded at start
    assign dvd_ext    = {{`SEXT_W{dividend_in[`DIVD_W-1]}}, dividend_in};
    assign dsr_scaled = {{`DSR_SEXT_W{divisor_in[`DSR_W-1]}}, divisor_in,
                         {`SCALE_SHIFT{1'b0}}};

    // sign agreement picks the reduction
    assign op_sub    = (rem[`WORK_W-1] == dsr[`WORK_W-1]);
    assign underflow = (sum[`WORK_W-1] != rem[`WORK_W-1]);
    assign qbit      = op_sub ? ~underflow : underflow;

    // leftover underflow, including a remainder of exactly one divisor
    assign need_fix = (rem != `WORK_ZERO) &&
                      ((rem[`WORK_W-1] != dvd_sign) || (rem == dsr) || (rem == (~dsr + 1'b1)));
    assign q_full   = {q[`DSR_W-1:1], 1'b1};
    assign abs_rem  = rem[`WORK_W-1] ? (~rem + 1'b1) : rem;
    assign abs_dsr  = dsr[`WORK_W-1] ? (~dsr + 1'b1) : dsr;

    addsub_unit #(
        .W      (`WORK_W)
    ) u_addsub (
        .a_in   (rem),
        .b_in   (dsr),
        .sub_in (op_sub),
        .sum_out(sum)
    );

    // ****************************************
    // sequencer next values
    // ****************************************
    always_comb begin
        next_state     = state;
        next_rem       = rem;
        next_dsr       = dsr;
        next_q         = q;
        next_cnt       = cnt;
        next_dvd_sign  = dvd_sign;
        next_done      = 1'b0;
        next_quotient  = quotient_out;
        next_remainder = remainder_out;
        next_overflow  = overflow_out;
        next_qcarry    = 1'b0;
        case (state)
            ST_IDLE: begin
                if (start_in) begin
                    next_rem      = dvd_ext;
                    next_dsr      = dsr_scaled;
                    next_q        = `QUO_ZERO;
                    next_cnt      = `STEP_COUNT;
                    next_dvd_sign = dividend_in[`DIVD_W-1];
                    next_state    = ST_STEP;
                end
            end
            ST_STEP: begin
                next_rem = sum;
                next_q   = {q[`DSR_W-2:0], qbit};
                next_cnt = cnt - `CNT_ONE;
                if (cnt != `CNT_ONE) begin
                    next_dsr = {dsr[`WORK_W-1], dsr[`WORK_W-1:1]};
                end else begin
                    next_state = ST_FIX;
                end
            end
            ST_FIX: begin
                if (need_fix) begin
                    next_rem = sum;
                    next_q   = op_sub ? (q_full + `QUO_ONE) : (q_full - `QUO_ONE);
                end else begin
                    next_q = q_full;
                end
                next_qcarry = need_fix && op_sub && (&q[`DSR_W-1:1]);
                next_state = ST_DONE;
            end
            ST_DONE: begin
                next_quotient  = q;
                next_remainder = rem[`DSR_W-1:0];
                next_overflow  = (dsr == `WORK_ZERO) || (abs_rem >= abs_dsr) ||
                                 ((dvd_sign ^ dsr[`WORK_W-1]) == !(qcarry | q[`DSR_W-1]));
                next_done      = 1'b1;
                next_state     = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            state         <= ST_IDLE;
            rem           <= `WORK_ZERO;
            dsr           <= `WORK_ZERO;
            q             <= `QUO_ZERO;
            cnt           <= '0;
            dvd_sign      <= 1'b0;
            done          <= 1'b0;
            quotient_out  <= `QUO_ZERO;
            remainder_out <= `REM_ZERO;
            overflow_out  <= 1'b0;
            qcarry        <= 1'b0;
        end else begin
            state         <= next_state;
            rem           <= next_rem;
            dsr           <= next_dsr;
            q             <= next_q;
            cnt           <= next_cnt;
            dvd_sign      <= next_dvd_sign;
            done          <= next_done;
            quotient_out  <= next_quotient;
            remainder_out <= next_remainder;
            overflow_out  <= next_overflow;
            qcarry        <= next_qcarry;
        end
    end

    // status to the sequencer
    assign busy_out = (state != ST_IDLE);
    assign done_out = done;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n);

    sequence s_steps;
        (state == ST_STEP) [*8] ##1 (state == ST_STEP) [*8];
    endsequence

    sequence s_finish;
        (state == ST_FIX) ##1 (state == ST_DONE) ##1 done_out;
    endsequence

    property p_load_dividend;
        (state == ST_IDLE && start_in) |=> (rem == $past(dvd_ext)) && (cnt == `STEP_COUNT);
    endproperty
    a_load_dividend: assert property (p_load_dividend)
        else $error("dividend not loaded at start");

    property p_scaled_divisor;
        (state == ST_IDLE && start_in) |=>
            (dsr[`WORK_W-4:`SCALE_SHIFT] == $past(divisor_in)) && (dsr[`SCALE_SHIFT-1:0] == '0);
    endproperty
    a_scaled_divisor: assert property (p_scaled_divisor)
        else $error("divisor not scaled at start");

    property p_halve;
        (state == ST_STEP && cnt != `CNT_ONE) |=>
            ($signed(dsr) == ($signed($past(dsr)) >>> 1));
    endproperty
    a_halve: assert property (p_halve)
        else $error("divisor not halved between steps");

    property p_op_select;
        (state == ST_STEP) |-> (sum == (op_sub ? rem - dsr : rem + dsr)) &&
                               (op_sub == (rem[`WORK_W-1] == dsr[`WORK_W-1]));
    endproperty
    a_op_select: assert property (p_op_select)
        else $error("wrong reduction chosen");

    property p_underflow;
        (state == ST_STEP) |=> (rem[`WORK_W-1] != $past(rem[`WORK_W-1])) == $past(underflow);
    endproperty
    a_underflow: assert property (p_underflow)
        else $error("underflow does not match sign change");

    property p_no_restore;
        (state == ST_STEP) |=> (rem == $past(sum));
    endproperty
    a_no_restore: assert property (p_no_restore)
        else $error("remainder restored mid division");

    property p_qbit_sub;
        (state == ST_STEP && op_sub) |=> (q[0] == !$past(underflow));
    endproperty
    a_qbit_sub: assert property (p_qbit_sub)
        else $error("quotient bit wrong after subtraction");

    property p_qbit_add;
        (state == ST_STEP && !op_sub) |=> (q[0] == $past(underflow));
    endproperty
    a_qbit_add: assert property (p_qbit_add)
        else $error("quotient bit wrong after addition");

    property p_fix;
        (state == ST_FIX && need_fix) |=> (rem == $past(sum));
    endproperty
    a_fix: assert property (p_fix)
        else $error("corrective step not applied");

    property p_sequence;
        (state == ST_IDLE && start_in) |=> s_steps ##1 s_finish;
    endproperty
    a_sequence: assert property (p_sequence)
        else $error("division did not take sixteen steps then finish");

    property p_results;
        (state == ST_DONE) |=> done_out && (remainder_out == $past(rem[`DSR_W-1:0])) &&
                               (quotient_out == $past(q));
    endproperty
    a_results: assert property (p_results)
        else $error("results not presented with done");

    property p_zero_divisor;
        (state == ST_DONE && dsr == `WORK_ZERO) |=> overflow_out;
    endproperty
    a_zero_divisor: assert property (p_zero_divisor)
        else $error("zero divisor not flagged as overflow");

endmodule : nonrestoring_divider

`default_nettype wire

// ### core/divider_regs.svh
// Purpose: named widths, counts and constants of the sequential divider
// Assumes: one 100 MHz clock, 10 ns period
// Notes:   definitions only
`ifndef DIVIDER_REGS_SVH
`define DIVIDER_REGS_SVH

// ****************************************
// operand and working widths
// ****************************************
`define DIVD_W      32
`define DSR_W       16
`define WORK_W      34
`define CNT_W       5
`define SEXT_W      2
`define DSR_SEXT_W  3

// ****************************************
// step control
// ****************************************
`define SCALE_SHIFT 15
`define STEP_COUNT  5'h10
`define CNT_ONE     5'h01
`define QUO_ZERO    16'h0000
`define QUO_ONE     16'h0001
`define REM_ZERO    16'h0000
`define WORK_ZERO   34'h0_0000_0000

`endif

// ### core/divider_pkg.sv
// Purpose: shared types of the sequential divider
// Assumes: nothing
// Notes:   numeric constants live in divider_regs.svh
package divider_pkg;

    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STEP,
        ST_FIX,
        ST_DONE
    } div_state_t;

endpackage : divider_pkg

// ### core/addsub_unit.sv
// Purpose: signed adder/subtractor for the working register
// Assumes: operands already sign-extended to the width
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none

module addsub_unit #(
    parameter int W = 34
) (
    input  wire logic [W-1:0] a_in,
    input  wire logic [W-1:0] b_in,
    input  wire logic         sub_in,
    output logic      [W-1:0] sum_out
);

    // a - b when sub_in, else a + b
    always_comb begin
        sum_out = sub_in ? (a_in - b_in) : (a_in + b_in);
    end

endmodule : addsub_unit

`default_nettype wire

// ### tb/sequencer_model.sv
// Purpose: behavioural control sequencer that feeds the divider
// Assumes: one clock, outputs change on the rising edge or at once when resetn_in falls
// Notes:   released operand lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
`include "divider_regs.svh"

module sequencer_model (
    input  wire logic                 clock_in,
    input  wire logic                 resetn_in,
    input  wire logic                 req_in,       // one division wanted
    input  wire logic                 poke_in,      // stray start while busy
    input  wire logic [`DIVD_W-1:0]   a_in,
    input  wire logic [`DSR_W-1:0]    b_in,
    input  wire logic                 done_in,
    output logic                      start_out,
    output logic      [`DIVD_W-1:0]   dividend_out,
    output logic      [`DSR_W-1:0]    divisor_out,
    output logic                      waiting_out,
    output logic      [5:0]           latency_out
);
    // ****************************************
    // request, hold, wait for done
    // ****************************************
    logic [5:0] cnt;

    // one-cycle start, operands held until done, then released
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            start_out    <= 1'b0;
            waiting_out  <= 1'b0;
            cnt          <= 6'h00;
            latency_out  <= 6'h00;
            dividend_out <= 32'h0000_0000;
            divisor_out  <= 16'h0000;
        end else begin
            start_out <= 1'b0;
            if (req_in && !waiting_out) begin
                start_out    <= 1'b1;
                dividend_out <= a_in;
                divisor_out  <= b_in;
                waiting_out  <= 1'b1;
                cnt          <= 6'h00;
            end else if (waiting_out) begin
                cnt <= cnt + 6'h01;
                if (poke_in) begin
                    start_out <= 1'b1; // refused by a busy divider
                end
                if (done_in) begin
                    waiting_out  <= 1'b0;
                    latency_out  <= cnt;
                    dividend_out <= ~dividend_out;
                    divisor_out  <= ~divisor_out;
                end
            end
        end
    end
endmodule : sequencer_model
`default_nettype wire

// ### tb/nonrestoring_divider_tb.sv
// Purpose: self-checking bench of the sequential divider
// Assumes: sequencer model drives the operand side
// Notes:   expected results from truncating integer division
`timescale 1ns/1ps
`default_nettype none

module nonrestoring_divider_tb;
    // ****************************************
    // signals and instances
    // ****************************************
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        req = 1'b0;
    logic        poke = 1'b0;
    logic [31:0] a = 32'h0000_0000;
    logic [15:0] b = 16'h0000;
    logic        start, busy, done, ovf, waiting;
    logic [31:0] dividend;
    logic [15:0] divisor, quo, rem;
    logic [5:0]  latency;
    int          failures = 0;
    int          check_count = 0;

    // 100 MHz clock
    always #5 clock = ~clock;

    nonrestoring_divider nonrestoring_divider_inst (.clock_in(clock), .resetn_in(resetn),
        .start_in(start), .dividend_in(dividend), .divisor_in(divisor), .busy_out(busy),
        .done_out(done), .quotient_out(quo), .remainder_out(rem), .overflow_out(ovf));

    sequencer_model sequencer_model_inst (.clock_in(clock), .resetn_in(resetn),
        .req_in(req), .poke_in(poke), .a_in(a), .b_in(b), .done_in(done),
        .start_out(start), .dividend_out(dividend), .divisor_out(divisor),
        .waiting_out(waiting), .latency_out(latency));

    // ****************************************
    // compare and report
    // ****************************************
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bit

    task automatic final_report();
        $display("failures=%0d check_count=%0d", failures, check_count);
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // one division through the model, results judged on return
    task automatic run_div(input logic [31:0] x, input logic [15:0] y, input logic bump);
        longint sx, sy, q, r;
        logic   ov;
        int     i;
        sx = $signed(x);
        sy = $signed(y);
        q = 0;
        r = 0;
        if (sy != 0) begin
            q = sx / sy;
            r = sx % sy;
        end
        ov = (sy == 0) || (q > 32767) || (q < -32768);
        @(posedge clock);
        req <= 1'b1;
        a   <= x;
        b   <= y;
        @(posedge clock);
        req <= 1'b0;
        for (i = 0; i < 100; i++) begin
            @(posedge clock);
            poke <= bump && (i == 4);
            #1;
            if (i == 0) check_bit(busy, 1'b1);
            if (i == 18) check_bit(done, 1'b1);
            if (waiting === 1'b0) break;
        end
        if (i == 100) begin
            failures++;
            final_report();
        end
        check_bit(ovf, ov);
        if (!ov) begin
            check_word(quo, q[15:0]);
            check_word(rem, r[15:0]);
        end
        // edges after the taking edge up to the edge that raises done
        check_word({10'h000, latency}, 16'h0013);
    endtask : run_div

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset_values();
        check_bit(busy, 1'b0);
        check_bit(done, 1'b0);
        check_bit(ovf, 1'b0);
        check_word(quo, 16'h0000);
        check_word(rem, 16'h0000);
    endtask : test_reset_values

    // all four sign pairings of 100 by 7
    task automatic test_signs();
        logic [31:0] xs [4] = '{32'h0000_0064, 32'hFFFF_FF9C, 32'h0000_0064, 32'hFFFF_FF9C};
        logic [15:0] ys [4] = '{16'h0007, 16'h0007, 16'hFFF9, 16'hFFF9};
        for (int k = 0; k < 4; k++) begin
            run_div(xs[k], ys[k], 1'b0);
        end
    endtask : test_signs

    // largest quotients that fit, then 21 by 7 and -21 by 7 with zero remainder
    task automatic test_bounds();
        run_div(32'h0003_7FFF, 16'h0007, 1'b0);
        run_div(32'hFFFC_8000, 16'h0007, 1'b0);
        run_div(32'h0000_0015, 16'h0007, 1'b0);
        run_div(32'hFFFF_FFEB, 16'h0007, 1'b0);
    endtask : test_bounds

    task automatic test_overflow();
        run_div(32'h0003_8000, 16'h0007, 1'b0);
        run_div(32'h0001_0000, 16'h0001, 1'b0);
        run_div(32'h0000_04D2, 16'h0000, 1'b0);
        run_div(32'h0000_0064, 16'h0007, 1'b0);
        run_div(32'hFFFF_0000, 16'h0001, 1'b0);
    endtask : test_overflow

    // start pulsed in mid-division must be ignored
    task automatic test_busy_start();
        run_div(32'h0000_03E8, 16'hFFFD, 1'b1);
    endtask : test_busy_start

    // reset in mid-division clears everything, then runs again
    task automatic test_mid_reset();
        @(posedge clock);
        req <= 1'b1;
        a   <= 32'h0000_03E8;
        b   <= 16'h0007;
        @(posedge clock);
        req <= 1'b0;
        repeat (8) @(posedge clock);
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        test_reset_values();
        @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        run_div(32'h0000_03E8, 16'h0007, 1'b0);
    endtask : test_mid_reset

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clock);
        #1;
        test_reset_values();
        @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        test_signs();
        test_bounds();
        test_overflow();
        test_busy_start();
        test_mid_reset();
        final_report();
    end
endmodule : nonrestoring_divider_tb
`default_nettype wire
